// *** design/page_cmd_pkg.sv ***
// Constants, command codes, register offsets and carrier types of the
// interrupt and page command handler.
// Assumes an 8-bit host register port and a protocol engine beside the core.
`default_nettype none

package page_cmd_pkg;

  // ==========================================================================
  // Widths and sizes
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned ADDR_W      = 4;
  localparam int unsigned PAGE_IDX_W  = 4;
  localparam int unsigned PAGE_COUNT  = 16;
  localparam int unsigned PAGE_ADDR_W = 5;
  localparam int unsigned PAGE_BYTES  = 32;
  localparam int unsigned QCOUNT_W    = 5;

  // ==========================================================================
  // Command codes
  localparam logic [7:0] CMD_SET_DESTINATION  = 8'h02;
  localparam logic [7:0] CMD_SET_LENGTH_LOW   = 8'h05;
  localparam logic [7:0] CMD_SET_PKT_ENABLES  = 8'h09;
  localparam logic [7:0] CMD_SET_SYS_ENABLES  = 8'h0A;
  localparam logic [7:0] CMD_CLEAR_SYS_FLAGS  = 8'h0B;
  localparam logic [7:0] CMD_CLEAR_PKT_FLAGS  = 8'h0D;
  localparam logic [7:0] CMD_SELECT_PAGE      = 8'h18;
  localparam logic [7:0] CMD_SET_SOURCE       = 8'h19;
  localparam logic [7:0] CMD_READ_PAGE_STATE  = 8'h27;
  localparam logic [7:0] CMD_LAUNCH_TRANSMIT  = 8'h35;

  // ==========================================================================
  // Register offsets on the host port
  localparam logic [3:0] REG_COMMAND      = 4'h0;
  localparam logic [3:0] REG_PARAMETER    = 4'h1;
  localparam logic [3:0] REG_PAGE_DATA    = 4'h2;
  localparam logic [3:0] REG_PAGE_ADDR    = 4'h3;
  localparam logic [3:0] REG_SYS_FLAGS    = 4'h4;
  localparam logic [3:0] REG_PKT_FLAGS    = 4'h5;
  localparam logic [3:0] REG_SYS_ENABLES  = 4'h6;
  localparam logic [3:0] REG_PKT_ENABLES  = 4'h7;
  localparam logic [3:0] REG_CURRENT_PAGE = 4'h8;
  localparam logic [3:0] REG_QUEUE_COUNT  = 4'h9;

  // ==========================================================================
  // Page header layout and reset values
  localparam logic [4:0] HDR_STATE       = 5'h00;
  localparam logic [4:0] HDR_LENGTH_LOW  = 5'h01;
  localparam logic [4:0] HDR_SOURCE      = 5'h02;
  localparam logic [4:0] HDR_DESTINATION = 5'h03;
  localparam logic [4:0] PAYLOAD_START   = 5'h04;
  localparam logic [7:0] BROADCAST_ID    = 8'h00;
  localparam logic [7:0] RESET_BYTE      = 8'h00;
  localparam logic [3:0] RESET_PAGE      = 4'h0;

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic [3:0] page;
    logic [7:0] state;
    logic [7:0] length_low;
    logic [7:0] source;
    logic [7:0] destination;
    logic       broadcast;
  } rx_header_t;

  typedef struct packed {
    logic [3:0] page;
    logic [4:0] addr;
    logic [7:0] data;
  } rx_byte_t;

  typedef struct packed {
    logic [3:0] page;
    logic [7:0] destination;
    logic       broadcast;
  } tx_request_t;

endpackage

`default_nettype wire

// *** design/irq_flag_group.sv ***
// One interrupt group: enable set loaded by command, sticky status flags.
// Assumes event pulses are synchronous to the core clock.
`default_nettype none

module irq_flag_group (
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  // Host side
  input  wire logic       i_load_enables,
  input  wire logic       i_clear,
  input  wire logic [7:0] i_value,
  // Event side
  input  wire logic [7:0] i_events,
  // State
  output logic      [7:0] o_flags,
  output logic      [7:0] o_enables
);

  // ==========================================================================
  // Enable set, loaded whole from the parameter byte
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_enables <= page_cmd_pkg::RESET_BYTE;
    end else if (i_load_enables) begin
      o_enables <= i_value;
    end
  end

  // ==========================================================================
  // Sticky flags; an event in the clearing cycle survives the clear
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_flags <= page_cmd_pkg::RESET_BYTE;
    end else begin
      o_flags <= (o_flags & ~(i_clear ? i_value : 8'h00))
               | (i_events & o_enables);
    end
  end

endmodule

`default_nettype wire

// *** design/irq_and_page_command_handler.sv ***
// Command interpreter for interrupt groups and the sixteen packet pages.
// Assumes a host port with one-cycle strobes and read data one cycle later,
// and a protocol engine that fills received pages and drains the send queue.
// Operation
// - Command 09 loads parameter byte into packet interrupt enables.
// - Command 0A loads parameter byte into system interrupt enables.
// - Command 0B clears system flags whose parameter bits are set.
// - Command 0D clears packet flags whose parameter bits are set.
// - Interrupt output stays high while any flag of either group is set.
// - Command 18 selects current page for later transfers and data accesses; command 35 queues the page in the low four parameter bits instead.
// - Page index comes from the low four parameter bits.
// - Page select puts the data pointer at byte four.
// - First four bytes of each page hold the header bookkeeping.
// - Received header: state, length low, source, destination at bytes 0-3.
// - Payload begins at byte four.
// - Destination byte of a received broadcast is not valid content.
// - Command 02 sets page destination; zero means broadcast.
// - Command 35 queues a page; pages go out in launch order.
//
// Added by the designer: the register offsets and strobed register access.
`default_nettype none

module irq_and_page_command_handler (
  // Clock and reset
  input  wire logic                      i_core_clk,
  input  wire logic                      i_rst,
  // Host register port
  input  wire logic [3:0]                i_addr,
  input  wire logic [7:0]                i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic      [7:0]                o_rdata,
  // Interrupt
  output logic                           o_irq,
  // Event sources from the protocol engine
  input  wire logic [7:0]                i_packet_events,
  input  wire logic [7:0]                i_system_events,
  // Receive side from the protocol engine
  input  wire logic                      i_rx_byte_valid,
  input  wire page_cmd_pkg::rx_byte_t    i_rx_byte,
  input  wire logic                      i_rx_header_valid,
  input  wire page_cmd_pkg::rx_header_t  i_rx_header,
  // Transmit queue toward the protocol engine
  output logic                           o_tx_valid,
  output page_cmd_pkg::tx_request_t      o_tx_request,
  input  wire logic                      i_tx_taken
);

  // ==========================================================================
  // Host decode
  logic       cmd_strobe;
  logic [7:0] code;
  logic [7:0] parameter_byte;
  logic [3:0] param_page;
  logic       data_wr;
  logic       data_rd;

  assign cmd_strobe = i_wr && (i_addr == page_cmd_pkg::REG_COMMAND);
  assign code       = i_wdata;
  assign param_page = parameter_byte[3:0];
  assign data_wr    = i_wr && (i_addr == page_cmd_pkg::REG_PAGE_DATA);
  assign data_rd    = i_rd && (i_addr == page_cmd_pkg::REG_PAGE_DATA);

  // ==========================================================================
  // Page storage and pointer
  logic [7:0] page_mem [page_cmd_pkg::PAGE_COUNT][page_cmd_pkg::PAGE_BYTES];
  logic [3:0] current_page;
  logic [4:0] data_ptr;

  // ==========================================================================
  // Parameter register; a page state query overwrites it with the answer
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      parameter_byte <= page_cmd_pkg::RESET_BYTE;
    end else if (i_wr && (i_addr == page_cmd_pkg::REG_PARAMETER)) begin
      parameter_byte <= i_wdata;
    end else if (cmd_strobe && (code == page_cmd_pkg::CMD_READ_PAGE_STATE)) begin
      parameter_byte <= page_mem[param_page][page_cmd_pkg::HDR_STATE];
    end
  end

  // ==========================================================================
  // Interrupt groups
  logic [7:0] packet_flags;
  logic [7:0] packet_enables;
  logic [7:0] system_flags;
  logic [7:0] system_enables;
  logic       packet_clear;
  logic       system_clear;
  logic [7:0] packet_clear_value;
  logic [7:0] system_clear_value;

  // Commands clear with the parameter, direct writes clear with the data
  assign packet_clear = (cmd_strobe && (code == page_cmd_pkg::CMD_CLEAR_PKT_FLAGS))
                      || (i_wr && (i_addr == page_cmd_pkg::REG_PKT_FLAGS));
  assign system_clear = (cmd_strobe && (code == page_cmd_pkg::CMD_CLEAR_SYS_FLAGS))
                      || (i_wr && (i_addr == page_cmd_pkg::REG_SYS_FLAGS));
  assign packet_clear_value = cmd_strobe ? parameter_byte : i_wdata;
  assign system_clear_value = cmd_strobe ? parameter_byte : i_wdata;

  irq_flag_group packet_group (
    .i_core_clk     (i_core_clk),
    .i_rst          (i_rst),
    .i_load_enables (cmd_strobe && (code == page_cmd_pkg::CMD_SET_PKT_ENABLES)),
    .i_clear        (packet_clear),
    .i_value        (packet_clear ? packet_clear_value : parameter_byte),
    .i_events       (i_packet_events),
    .o_flags        (packet_flags),
    .o_enables      (packet_enables)
  );

  irq_flag_group system_group (
    .i_core_clk     (i_core_clk),
    .i_rst          (i_rst),
    .i_load_enables (cmd_strobe && (code == page_cmd_pkg::CMD_SET_SYS_ENABLES)),
    .i_clear        (system_clear),
    .i_value        (system_clear ? system_clear_value : parameter_byte),
    .i_events       (i_system_events),
    .o_flags        (system_flags),
    .o_enables      (system_enables)
  );

  // Level output drops only once both groups are empty
  assign o_irq = (|packet_flags) || (|system_flags);

  // ==========================================================================
  // Current page selection
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      current_page <= page_cmd_pkg::RESET_PAGE;
    end else if (cmd_strobe && (code == page_cmd_pkg::CMD_SELECT_PAGE)) begin
      current_page <= param_page;
    end
  end

  // ==========================================================================
  // Data pointer: starts past the header, walks one byte per access
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      data_ptr <= page_cmd_pkg::PAYLOAD_START;
    end else if (cmd_strobe && (code == page_cmd_pkg::CMD_SELECT_PAGE)) begin
      data_ptr <= page_cmd_pkg::PAYLOAD_START;
    end else if (i_wr && (i_addr == page_cmd_pkg::REG_PAGE_ADDR)) begin
      data_ptr <= i_wdata[4:0];
    end else if (data_wr || data_rd) begin
      data_ptr <= data_ptr + 5'h01;
    end
  end

  // ==========================================================================
  // Page writes; later statements win, so the engine beats the host
  // on the rare cycle where both hit the same byte
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int p = 0; p < page_cmd_pkg::PAGE_COUNT; p++) begin
        for (int b = 0; b < page_cmd_pkg::PAGE_BYTES; b++) begin
          page_mem[p][b] <= page_cmd_pkg::RESET_BYTE;
        end
      end
    end else begin
      if (data_wr) begin
        page_mem[current_page][data_ptr] <= i_wdata;
      end
      if (cmd_strobe && (code == page_cmd_pkg::CMD_SET_DESTINATION)) begin
        page_mem[current_page][page_cmd_pkg::HDR_DESTINATION] <= parameter_byte;
      end
      if (cmd_strobe && (code == page_cmd_pkg::CMD_SET_LENGTH_LOW)) begin
        page_mem[current_page][page_cmd_pkg::HDR_LENGTH_LOW] <= parameter_byte;
      end
      if (cmd_strobe && (code == page_cmd_pkg::CMD_SET_SOURCE)) begin
        page_mem[current_page][page_cmd_pkg::HDR_SOURCE] <= parameter_byte;
      end
      if (i_rx_byte_valid) begin
        page_mem[i_rx_byte.page][i_rx_byte.addr] <= i_rx_byte.data;
      end
      if (i_rx_header_valid) begin
        page_mem[i_rx_header.page][page_cmd_pkg::HDR_STATE] <= i_rx_header.state;
        page_mem[i_rx_header.page][page_cmd_pkg::HDR_LENGTH_LOW] <= i_rx_header.length_low;
        page_mem[i_rx_header.page][page_cmd_pkg::HDR_SOURCE] <= i_rx_header.source;
        // A broadcast carries no destination worth keeping
        page_mem[i_rx_header.page][page_cmd_pkg::HDR_DESTINATION] <=
          i_rx_header.broadcast ? page_cmd_pkg::BROADCAST_ID
                                : i_rx_header.destination;
      end
    end
  end

  // ==========================================================================
  // Transmit queue: pages leave in launch order; a launch into a full
  // queue is dropped, which software sees in the queue count
  logic [3:0] queue_mem [page_cmd_pkg::PAGE_COUNT];
  logic [3:0] queue_head;
  logic [3:0] queue_tail;
  logic [4:0] queue_count;
  logic       queue_push;
  logic       queue_pop;

  assign queue_push = cmd_strobe && (code == page_cmd_pkg::CMD_LAUNCH_TRANSMIT)
                    && (queue_count != 5'h10);
  assign queue_pop  = i_tx_taken && (queue_count != 5'h00);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int q = 0; q < page_cmd_pkg::PAGE_COUNT; q++) begin
        queue_mem[q] <= page_cmd_pkg::RESET_PAGE;
      end
    end else if (queue_push) begin
      queue_mem[queue_tail] <= param_page;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      queue_head  <= 4'h0;
      queue_tail  <= 4'h0;
      queue_count <= 5'h00;
    end else begin
      if (queue_push) begin
        queue_tail <= queue_tail + 4'h1;
      end
      if (queue_pop) begin
        queue_head <= queue_head + 4'h1;
      end
      queue_count <= queue_count + {4'h0, queue_push} - {4'h0, queue_pop};
    end
  end

  // Head request; destination zero turns it into a broadcast
  assign o_tx_valid               = (queue_count != 5'h00);
  assign o_tx_request.page        = queue_mem[queue_head];
  assign o_tx_request.destination =
    page_mem[queue_mem[queue_head]][page_cmd_pkg::HDR_DESTINATION];
  assign o_tx_request.broadcast   =
    (o_tx_request.destination == page_cmd_pkg::BROADCAST_ID);

  // ==========================================================================
  // Read data, standing only in the cycle after the strobe
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= page_cmd_pkg::RESET_BYTE;
    end else if (!i_rd) begin
      o_rdata <= page_cmd_pkg::RESET_BYTE;
    end else begin
      case (i_addr)
        page_cmd_pkg::REG_PARAMETER:    o_rdata <= parameter_byte;
        page_cmd_pkg::REG_PAGE_DATA:    o_rdata <= page_mem[current_page][data_ptr];
        page_cmd_pkg::REG_PAGE_ADDR:    o_rdata <= {3'h0, data_ptr};
        page_cmd_pkg::REG_SYS_FLAGS:    o_rdata <= system_flags;
        page_cmd_pkg::REG_PKT_FLAGS:    o_rdata <= packet_flags;
        page_cmd_pkg::REG_SYS_ENABLES:  o_rdata <= system_enables;
        page_cmd_pkg::REG_PKT_ENABLES:  o_rdata <= packet_enables;
        page_cmd_pkg::REG_CURRENT_PAGE: o_rdata <= {4'h0, current_page};
        page_cmd_pkg::REG_QUEUE_COUNT:  o_rdata <= {3'h0, queue_count};
        default:                        o_rdata <= page_cmd_pkg::RESET_BYTE;
      endcase
    end
  end

  // ==========================================================================
  // Assertions
  sequence seq_select_page;
    cmd_strobe && (code == page_cmd_pkg::CMD_SELECT_PAGE);
  endsequence

  sequence seq_quiet_pointer;
    !(i_wr && (i_addr == page_cmd_pkg::REG_PAGE_ADDR)) && !cmd_strobe;
  endsequence

  sequence seq_first_read;
    data_rd && !cmd_strobe;
  endsequence

  sequence seq_bus_idle;
    !i_wr && !i_rd;
  endsequence

  AST_PKT_ENABLE_LOAD: assert property (@(posedge i_core_clk) disable iff (i_rst)
    cmd_strobe && (code == page_cmd_pkg::CMD_SET_PKT_ENABLES)
    |=> packet_enables == $past(parameter_byte))
    else $error("packet enables not loaded from parameter");

  AST_SYS_ENABLE_LOAD: assert property (@(posedge i_core_clk) disable iff (i_rst)
    cmd_strobe && (code == page_cmd_pkg::CMD_SET_SYS_ENABLES)
    |=> system_enables == $past(parameter_byte))
    else $error("system enables not loaded from parameter");

  AST_SYS_CLEAR: assert property (@(posedge i_core_clk) disable iff (i_rst)
    cmd_strobe && (code == page_cmd_pkg::CMD_CLEAR_SYS_FLAGS) && (i_system_events == 8'h00)
    |=> system_flags == ($past(system_flags) & ~$past(parameter_byte)))
    else $error("system flags not cleared by mask");

  AST_PKT_CLEAR: assert property (@(posedge i_core_clk) disable iff (i_rst)
    cmd_strobe && (code == page_cmd_pkg::CMD_CLEAR_PKT_FLAGS) && (i_packet_events == 8'h00)
    |=> packet_flags == ($past(packet_flags) & ~$past(parameter_byte)))
    else $error("packet flags not cleared by mask");

  AST_IRQ_LEVEL: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_irq == ((packet_flags != 8'h00) || (system_flags != 8'h00)))
    else $error("interrupt level disagrees with flags");

  // The level alone follows the flags by wiring; a rise must come from an enabled event
  logic enabled_event;
  assign enabled_event = |(i_packet_events & packet_enables)
                       || |(i_system_events & system_enables);

  AST_IRQ_RISE: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $rose(o_irq) |-> $past(enabled_event))
    else $error("interrupt rose without an enabled event");

  AST_PAGE_SELECT: assert property (@(posedge i_core_clk) disable iff (i_rst)
    seq_select_page |=> current_page == $past(parameter_byte[3:0]))
    else $error("current page not taken from parameter");

  // The host may leave one idle cycle between the select and the first read
  AST_POINTER_START: assert property (@(posedge i_core_clk) disable iff (i_rst)
    seq_select_page ##1 (seq_first_read or (seq_bus_idle ##1 seq_first_read))
    |=> (data_ptr == 5'h05) && (o_rdata == page_mem[current_page][5'h04]))
    else $error("first access after page select not at byte four");

  AST_POINTER_STEP: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (data_wr || data_rd) and seq_quiet_pointer
    |=> data_ptr == $past(data_ptr) + 5'h01)
    else $error("data pointer did not advance by one");

  AST_HEADER_STORE: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_rx_header_valid |=>
      page_mem[$past(i_rx_header.page)][5'h01] == $past(i_rx_header.length_low)
      && page_mem[$past(i_rx_header.page)][5'h02] == $past(i_rx_header.source))
    else $error("received header bytes misplaced");

  AST_BROADCAST_DEST: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_rx_header_valid && i_rx_header.broadcast
    |=> page_mem[$past(i_rx_header.page)][5'h03] == 8'h00)
    else $error("broadcast destination byte kept");

  AST_QUEUE_ORDER: assert property (@(posedge i_core_clk) disable iff (i_rst)
    cmd_strobe && (code == page_cmd_pkg::CMD_LAUNCH_TRANSMIT) && (queue_count == 5'h00)
    |=> o_tx_valid && (o_tx_request.page == $past(parameter_byte[3:0])))
    else $error("launched page not at queue head");

endmodule

`default_nettype wire

// *** test/engine_model.sv ***
// Protocol engine model: event pulses, received pages, send queue taker.
// Assumes one core clock; every task starts on or after a rising edge.
`default_nettype none

module engine_model (
  // Clock
  input  wire logic                 i_core_clk,
  // Toward the handler
  output logic      [7:0]           o_packet_events,
  output logic      [7:0]           o_system_events,
  output logic                      o_rx_byte_valid,
  output page_cmd_pkg::rx_byte_t    o_rx_byte,
  output logic                      o_rx_header_valid,
  output page_cmd_pkg::rx_header_t  o_rx_header,
  output logic                      o_tx_taken
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Idle state; payload lines carry a pattern so stale data never matches
  initial begin
    o_packet_events   = 8'h00;
    o_system_events   = 8'h00;
    o_rx_byte_valid   = 1'b0;
    o_rx_byte         = '1;
    o_rx_header_valid = 1'b0;
    o_rx_header       = '1;
    o_tx_taken        = 1'b0;
  end

  // One-cycle event pulses on both groups
  task automatic events(input logic [7:0] p, input logic [7:0] s);
    @(posedge i_core_clk);
    o_packet_events <= p;
    o_system_events <= s;
    @(posedge i_core_clk);
    o_packet_events <= 8'h00;
    o_system_events <= 8'h00;
  endtask

  // Received header, then scrambled once valid drops
  task automatic header(input page_cmd_pkg::rx_header_t h);
    @(posedge i_core_clk);
    o_rx_header_valid <= 1'b1;
    o_rx_header       <= h;
    @(posedge i_core_clk);
    o_rx_header_valid <= 1'b0;
    o_rx_header       <= ~h;
  endtask

  // One received payload byte
  task automatic rx_byte(input page_cmd_pkg::rx_byte_t b);
    @(posedge i_core_clk);
    o_rx_byte_valid <= 1'b1;
    o_rx_byte       <= b;
    @(posedge i_core_clk);
    o_rx_byte_valid <= 1'b0;
    o_rx_byte       <= ~b;
  endtask

  // Pops the head of the send queue
  task automatic take();
    @(posedge i_core_clk);
    o_tx_taken <= 1'b1;
    @(posedge i_core_clk);
    o_tx_taken <= 1'b0;
  endtask
endmodule

`default_nettype wire

// *** test/irq_and_page_command_handler_tb_top.sv ***
// Self-checking bench of the interrupt and page command handler.
// Assumes the engine model on the far side and the host port driven here.
`default_nettype none

module irq_and_page_command_handler_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Signals
  logic                     i_core_clk = 1'b0;
  logic                     i_rst      = 1'b1;
  logic [3:0]               i_addr     = 4'h0;
  logic [7:0]               i_wdata    = 8'h00;
  logic                     i_wr       = 1'b0;
  logic                     i_rd       = 1'b0;
  logic [7:0]               o_rdata;
  logic                     o_irq;
  logic [7:0]               pkt_ev;
  logic [7:0]               sys_ev;
  logic                     rxb_v;
  page_cmd_pkg::rx_byte_t   rxb;
  logic                     rxh_v;
  page_cmd_pkg::rx_header_t rxh;
  logic                     tx_v;
  page_cmd_pkg::tx_request_t tx_req;
  logic                     tx_taken;
  int                       fails     = 0;
  int                       cmp_count = 0;
  int                       cycles    = 0;

  // ==========================================================================
  // Clock, device and far side
  initial begin
    forever #5 i_core_clk = ~i_core_clk;
  end

  irq_and_page_command_handler dut (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_irq(o_irq), .i_packet_events(pkt_ev), .i_system_events(sys_ev),
    .i_rx_byte_valid(rxb_v), .i_rx_byte(rxb), .i_rx_header_valid(rxh_v),
    .i_rx_header(rxh), .o_tx_valid(tx_v), .o_tx_request(tx_req), .i_tx_taken(tx_taken));

  engine_model eng (.i_core_clk(i_core_clk), .o_packet_events(pkt_ev),
    .o_system_events(sys_ev), .o_rx_byte_valid(rxb_v), .o_rx_byte(rxb),
    .o_rx_header_valid(rxh_v), .o_rx_header(rxh), .o_tx_taken(tx_taken));

  // ==========================================================================
  // Reporting and host bus tasks
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask

  // One-cycle write strobe, released at the taking edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e, input string n);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 chk(n, e, o_rdata);
  endtask

  task automatic cmd(input logic [7:0] c, input logic [7:0] p);
    wr(page_cmd_pkg::REG_PARAMETER, p);
    wr(page_cmd_pkg::REG_COMMAND, c);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_irq();
    cmd(page_cmd_pkg::CMD_SET_PKT_ENABLES, 8'hFF);
    cmd(page_cmd_pkg::CMD_SET_SYS_ENABLES, 8'h0F);
    rdchk(page_cmd_pkg::REG_PKT_ENABLES, 8'hFF, "pkt_en");
    rdchk(page_cmd_pkg::REG_SYS_ENABLES, 8'h0F, "sys_en");
    eng.events(8'h81, 8'hF1);
    #1 chk("irq", 8'h01, {7'h00, o_irq});
    rdchk(page_cmd_pkg::REG_SYS_FLAGS, 8'h01, "sys_fl");
    cmd(page_cmd_pkg::CMD_CLEAR_PKT_FLAGS, 8'h01);
    rdchk(page_cmd_pkg::REG_PKT_FLAGS, 8'h80, "pkt_fl");
    cmd(page_cmd_pkg::CMD_CLEAR_SYS_FLAGS, 8'hFE);
    rdchk(page_cmd_pkg::REG_SYS_FLAGS, 8'h01, "sys_fl");
    cmd(page_cmd_pkg::CMD_CLEAR_SYS_FLAGS, 8'h01);
    chk("irq", 8'h01, {7'h00, o_irq});
    wr(page_cmd_pkg::REG_PKT_FLAGS, 8'h80);
    chk("irq", 8'h00, {7'h00, o_irq});
  endtask

  task automatic t_page();
    logic [7:0] e[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hA1, 8'hA2};
    cmd(page_cmd_pkg::CMD_SELECT_PAGE, 8'h13);
    rdchk(page_cmd_pkg::REG_CURRENT_PAGE, 8'h03, "page");
    rdchk(page_cmd_pkg::REG_PAGE_ADDR, 8'h04, "ptr");
    wr(page_cmd_pkg::REG_PAGE_DATA, 8'hA1);
    wr(page_cmd_pkg::REG_PAGE_DATA, 8'hA2);
    rdchk(page_cmd_pkg::REG_PAGE_ADDR, 8'h06, "ptr");
    wr(page_cmd_pkg::REG_PAGE_ADDR, 8'h00);
    for (int i = 0; i < 6; i++) rdchk(page_cmd_pkg::REG_PAGE_DATA, e[i], "pg");
  endtask

  task automatic t_rx();
    logic [7:0] e[5] = '{8'h55, 8'h20, 8'h11, 8'h22, 8'h99};
    eng.header('{page: 4'h7, state: 8'h55, length_low: 8'h20, source: 8'h11,
                 destination: 8'h22, broadcast: 1'b0});
    eng.rx_byte('{page: 4'h7, addr: 5'h04, data: 8'h99});
    cmd(page_cmd_pkg::CMD_SELECT_PAGE, 8'h07);
    wr(page_cmd_pkg::REG_PAGE_ADDR, 8'h00);
    for (int i = 0; i < 5; i++) rdchk(page_cmd_pkg::REG_PAGE_DATA, e[i], "hdr");
    cmd(page_cmd_pkg::CMD_SELECT_PAGE, 8'h07);
    rdchk(page_cmd_pkg::REG_PAGE_DATA, 8'h99, "first");
    eng.header('{page: 4'h8, state: 8'h66, length_low: 8'h01, source: 8'h12,
                 destination: 8'h44, broadcast: 1'b1});
    cmd(page_cmd_pkg::CMD_SELECT_PAGE, 8'h08);
    wr(page_cmd_pkg::REG_PAGE_ADDR, 8'h03);
    rdchk(page_cmd_pkg::REG_PAGE_DATA, 8'h00, "bc_dst");
  endtask

  task automatic t_tx();
    cmd(page_cmd_pkg::CMD_READ_PAGE_STATE, 8'h07);
    rdchk(page_cmd_pkg::REG_PARAMETER, 8'h55, "pstate");
    cmd(page_cmd_pkg::CMD_SELECT_PAGE, 8'h05);
    cmd(page_cmd_pkg::CMD_SET_DESTINATION, 8'h00);
    cmd(page_cmd_pkg::CMD_LAUNCH_TRANSMIT, 8'h05);
    cmd(page_cmd_pkg::CMD_SELECT_PAGE, 8'h09);
    cmd(page_cmd_pkg::CMD_SET_DESTINATION, 8'h33);
    cmd(page_cmd_pkg::CMD_SET_LENGTH_LOW, 8'h02);
    cmd(page_cmd_pkg::CMD_SET_SOURCE, 8'h0C);
    cmd(page_cmd_pkg::CMD_LAUNCH_TRANSMIT, 8'hF9);
    wr(page_cmd_pkg::REG_PAGE_ADDR, 8'h01);
    rdchk(page_cmd_pkg::REG_PAGE_DATA, 8'h02, "len");
    rdchk(page_cmd_pkg::REG_PAGE_DATA, 8'h0C, "src");
    rdchk(page_cmd_pkg::REG_QUEUE_COUNT, 8'h02, "qcnt");
    chk("head", 8'h15, {3'h0, tx_v, tx_req.page});
    chk("bcast", 8'h01, {7'h00, tx_req.broadcast});
    eng.take();
    #1 chk("head", 8'h19, {3'h0, tx_v, tx_req.page});
    chk("dest", 8'h66, {tx_req.destination[6:0], tx_req.broadcast});
    eng.take();
    #1 chk("empty", 8'h00, {7'h00, tx_v});
  endtask

  // ==========================================================================
  // Main sequence and hang guard
  initial begin
    repeat (16) @(posedge i_core_clk);
    i_rst <= 1'b0;
    rdchk(4'hF, 8'h00, "unmapped");
    t_irq();
    t_page();
    t_rx();
    t_tx();
    print_verdict();
  end

  always @(posedge i_core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      print_verdict();
    end
  end
endmodule

`default_nettype wire
